/* File: core/ptb_defines.svh */
// Constants for the target burst back-end port
`ifndef PTB_DEFINES_SVH
`define PTB_DEFINES_SVH

// Bus command codes
`define PTB_CMD_MEM_RD   4'h6
`define PTB_CMD_MEM_WR   4'h7
`define PTB_CMD_CFG_RD   4'ha
`define PTB_CMD_CFG_WR   4'hb

// Configuration register select field and size
`define PTB_CFG_IDX_HI   7
`define PTB_CFG_IDX_LO   2
`define PTB_CFG_IDX_W    6
`define PTB_CFG_DEPTH    64
`define PTB_BAR0_IDX     6'h04
`define PTB_BAR1_IDX     6'h05

// Space sizes in address bits (bytes = 2**N); PTB_ADDR_W is the back-end dword address width
`define PTB_BAR0_W       24
`define PTB_BAR1_W       12
`define PTB_ADDR_W       22

// Data path widths
`define PTB_AD_W         64
`define PTB_CBE_W        8
`define PTB_DW_W         32

// Back-end latency count driven out, and data-phase lead-in counts
`define PTB_LATENCY      3'h0
`define PTB_CFG_RD_WAIT  2'h2
`define PTB_MEM_WAIT     2'h1
`define PTB_CNT_MAX      2'h3

// Address step per back-end word, narrow and wide
`define PTB_STEP32       22'h000001
`define PTB_STEP64       22'h000002

`endif

/* File: core/ptb_pkg.sv */
// Types shared by the target burst back-end port
package ptb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DECODE,
		ST_START,
		ST_CLAIM,
		ST_DATA,
		ST_TURN,
		ST_DONE
	} ptb_state_e;

	typedef struct packed {
		logic [63:0] ad;
		logic [7:0]  command_byte_enable_bus_n;
		logic        frame_n;
		logic        irdy_n;
		logic        idsel;
		logic        req64_n;
	} ptb_pci_in_s;

	typedef struct packed {
		logic [63:0] ad_o;
		logic        ad_lo_oe;
		logic        ad_hi_oe;
		logic        devsel_n;
		logic        trdy_n;
		logic        stop_n;
		logic        ack64_n;
		logic        ctl_oe;
		logic        par;
		logic        par_oe;
		logic        par64;
		logic        par64_oe;
	} ptb_pci_out_s;

	typedef struct packed {
		logic        backend_read_ready;
		logic        backend_write_ready;
		logic [63:0] rdata;
	} ptb_be_in_s;

	typedef struct packed {
		logic        access_start_pulse;
		logic        wide_access_start_pulse;
		logic        access_finished;
		logic        primary_space_hit;
		logic        secondary_space_hit;
		logic        config_space_access;
		logic        read_direction;
		logic        write_direction;
		logic        read_data_strobe;
		logic        read_data_strobe_upper;
		logic [3:0]  write_lane_qualifier;
		logic [3:0]  write_lane_qualifier_upper;
		logic [21:0] addr;
		logic [63:0] wdata;
		logic [2:0]  backend_latency_count;
	} ptb_be_out_s;

endpackage

/* File: core/ptb_cfg_ram.sv */
// Configuration register store with byte writes and registered read data
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"

module ptb_cfg_ram (
	input  wire logic        mclk,      // Clock
	input  wire logic        rst_n,     // Async reset, active low
	input  wire logic        we,        // Write strobe
	input  wire logic [3:0]  be,        // Byte lanes to write
	input  wire logic [5:0]  waddr,     // Write word index
	input  wire logic [31:0] wdata,     // Write data
	input  wire logic        re,        // Read strobe
	input  wire logic [5:0]  raddr,     // Read word index
	output logic      [31:0] rdata_ff   // Read data, one cycle after re
);

	logic [31:0] mem [`PTB_CFG_DEPTH];

	// Array itself is not reset; unwritten words read as whatever powered up
	always_ff @(posedge mclk)
	begin
		if (we)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (be[i])
					mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0000_0000;
		else if (re)
			rdata_ff <= mem[raddr];
	end

endmodule
`default_nettype wire

/* File: core/ptb_target.sv */
// Target data path bridging bus cycles to a generic back-end port
// Summary of operation
// - Config narrow; memory narrow or wide
// - Wide controls mirror narrow ones in wide accesses only
// - Wide build: 64-bit data, 8 command lanes
// - IDSEL only for config; index from bits 7:2
// - IDSEL, FRAMEn, command 1011: config write
// - IDSEL, FRAMEn, command 1010: config read
// - Config write: claim 4, ready 5, drop 6
// - Config read: ready and data 7, drop 8
// - Config space accepts bursts and singles
// - Memory bursts: one or two dwords every clock
// - Start pulse on hit; qualifiers held till next
// - Wide start with start means wide access
// - Write ready from back-end; lanes qualify data
// - Read ready, then strobe, bus next cycle
// - Address advances after each active qualifier
// - Wide transfers advance address by two
// - Memory write 0111, read 0110, base compare
// - Start in cycle 3, claim in cycle 4
// - REQ64n hit: wide start and ACK64n
// - Back-end data from cycle 7 every clock
// - Ready drops 9 write, 10 read; done 10 write, 11 read
// - Latency count zero: data with address
// - Write qualifier: one bit per lane
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"

module ptb_target (
	input  wire logic                 mclk,     // Bus clock
	input  wire logic                 rst_n,    // Async reset, active low
	input  wire ptb_pkg::ptb_pci_in_s pci_in,   // Bus pins sampled
	output ptb_pkg::ptb_pci_out_s     pci_out,  // Bus pins driven, with enables
	input  wire ptb_pkg::ptb_be_in_s  be_in,    // Back-end ready and read data
	output ptb_pkg::ptb_be_out_s      be_out    // Back-end strobes, address, data
);

	ptb_pkg::ptb_state_e st_ff, nxt_st;
	logic [31:0]  addr_ff, nxt_addr;
	logic [3:0]   cmd_ff, nxt_cmd;
	logic         cfg_sel_ff, nxt_cfg_sel;
	logic         req64_ff, nxt_req64;
	logic         frame_prev_ff, nxt_frame_prev;
	logic         prim_ff, nxt_prim;
	logic         sec_ff, nxt_sec;
	logic         cfg_ff, nxt_cfg;
	logic         rd_ff, nxt_rd;
	logic         wr_ff, nxt_wr;
	logic         wide_ff, nxt_wide;
	logic [1:0]   cnt_ff, nxt_cnt;
	logic         valid_ff, nxt_valid;
	logic [63:0]  ad_out_ff, nxt_ad_out;
	logic [21:0]  be_addr_ff, nxt_be_addr;
	logic [5:0]   cfg_idx_ff, nxt_cfg_idx;
	logic [63:0]  wdata_ff, nxt_wdata;
	logic [3:0]   qual_ff, nxt_qual;
	logic [3:0]   qual_hi_ff, nxt_qual_hi;
	logic [7:0]   bar0_ff, nxt_bar0;
	logic [19:0]  bar1_ff, nxt_bar1;
	logic         par_ff, nxt_par;
	logic         par64_ff, nxt_par64;
	logic         par_oe_ff, nxt_par_oe;
	logic         par64_oe_ff, nxt_par64_oe;

	logic         addr_phase;
	logic         trdy;
	logic         xfer;
	logic         rd_strobe;
	logic         cfg_re;
	logic         cfg_we;
	logic         ad_lo_oe;
	logic         ad_hi_oe;
	logic [31:0]  cfg_rdata;
	logic [3:0]   lanes;

	// Base registers read back from their flops, the rest from the store
	function automatic logic [31:0] cfg_word(input logic [5:0] idx, input logic [31:0] mem,
		input logic [7:0] b0, input logic [19:0] b1);
		if (idx == `PTB_BAR0_IDX)
			cfg_word = {b0, 24'h00_0000};
		else if (idx == `PTB_BAR1_IDX)
			cfg_word = {b1, 12'h000};
		else
			cfg_word = mem;
	endfunction

	ptb_cfg_ram u_cfg_ram (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.we       (cfg_we),
		.be       (lanes),
		.waddr    (cfg_idx_ff),
		.wdata    (pci_in.ad[31:0]),
		.re       (cfg_re),
		.raddr    (cfg_idx_ff),
		.rdata_ff (cfg_rdata)
	);

	assign lanes = ~pci_in.command_byte_enable_bus_n[3:0];

	// Handshakes from state and back-end ready
	always_comb
	begin
		addr_phase = (st_ff == ptb_pkg::ST_IDLE) && !pci_in.frame_n && frame_prev_ff;
		trdy = 1'b0;
		if (st_ff == ptb_pkg::ST_DATA)
		begin
			if (cfg_ff && wr_ff)
				trdy = 1'b1;
			else if (wr_ff)
				trdy = (cnt_ff != 2'h0) && be_in.backend_write_ready;
			else
				trdy = valid_ff;
		end
		xfer = trdy && !pci_in.irdy_n;
		// strobe only while a slot is free and more data is wanted
		rd_strobe = (st_ff == ptb_pkg::ST_DATA) && rd_ff && !cfg_ff && (cnt_ff != 2'h0)
			&& be_in.backend_read_ready && (!valid_ff || (xfer && !pci_in.frame_n));
		// config read fetched in time for cycle 7
		cfg_re = (st_ff == ptb_pkg::ST_DATA) && cfg_ff && rd_ff && (cnt_ff == 2'h0);
		cfg_we = xfer && cfg_ff && wr_ff;
		ad_lo_oe = (st_ff == ptb_pkg::ST_DATA) && rd_ff;
		ad_hi_oe = ad_lo_oe && wide_ff;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_addr = addr_ff;
		nxt_cmd = cmd_ff;
		nxt_cfg_sel = cfg_sel_ff;
		nxt_req64 = req64_ff;
		nxt_frame_prev = pci_in.frame_n;
		nxt_prim = prim_ff;
		nxt_sec = sec_ff;
		nxt_cfg = cfg_ff;
		nxt_rd = rd_ff;
		nxt_wr = wr_ff;
		nxt_wide = wide_ff;
		nxt_cnt = cnt_ff;
		nxt_valid = valid_ff;
		nxt_ad_out = ad_out_ff;
		nxt_be_addr = be_addr_ff;
		nxt_cfg_idx = cfg_idx_ff;
		nxt_wdata = wdata_ff;
		nxt_qual = 4'h0;
		nxt_qual_hi = 4'h0;
		nxt_bar0 = bar0_ff;
		nxt_bar1 = bar1_ff;
		nxt_par = ^{ad_out_ff[31:0], pci_in.command_byte_enable_bus_n[3:0]};
		nxt_par64 = ^{ad_out_ff[63:32], pci_in.command_byte_enable_bus_n[7:4]};
		nxt_par_oe = ad_lo_oe;
		nxt_par64_oe = ad_hi_oe;
		case (st_ff)
			ptb_pkg::ST_IDLE:
			begin
				if (addr_phase)
				begin
					nxt_addr = pci_in.ad[31:0];
					nxt_cmd = pci_in.command_byte_enable_bus_n[3:0];
					// select sampled only with config commands
					nxt_cfg_sel = pci_in.idsel && ((pci_in.command_byte_enable_bus_n[3:0]
						== `PTB_CMD_CFG_RD) || (pci_in.command_byte_enable_bus_n[3:0]
						== `PTB_CMD_CFG_WR));
					nxt_req64 = !pci_in.req64_n;
					nxt_st = ptb_pkg::ST_DECODE;
				end
			end
			ptb_pkg::ST_DECODE:
			begin
				nxt_prim = ((cmd_ff == `PTB_CMD_MEM_RD) || (cmd_ff == `PTB_CMD_MEM_WR))
					&& (addr_ff[31:`PTB_BAR0_W] == bar0_ff);
				nxt_sec = ((cmd_ff == `PTB_CMD_MEM_RD) || (cmd_ff == `PTB_CMD_MEM_WR))
					&& (addr_ff[31:`PTB_BAR1_W] == bar1_ff) && !nxt_prim;
				nxt_cfg = cfg_sel_ff;
				nxt_rd = (cmd_ff == `PTB_CMD_MEM_RD) || (cfg_sel_ff && cmd_ff == `PTB_CMD_CFG_RD);
				nxt_wr = (cmd_ff == `PTB_CMD_MEM_WR) || (cfg_sel_ff && cmd_ff == `PTB_CMD_CFG_WR);
				nxt_wide = req64_ff && (nxt_prim || nxt_sec);
				nxt_be_addr = addr_ff[`PTB_BAR0_W-1:2];
				nxt_cfg_idx = addr_ff[`PTB_CFG_IDX_HI:`PTB_CFG_IDX_LO];
				// a miss must not disturb qualifiers held since the last start
				if (nxt_prim || nxt_sec || cfg_sel_ff)
					nxt_st = ptb_pkg::ST_START;
				else
				begin
					nxt_prim = prim_ff;
					nxt_sec = sec_ff;
					nxt_cfg = cfg_ff;
					nxt_rd = rd_ff;
					nxt_wr = wr_ff;
					nxt_wide = wide_ff;
					nxt_be_addr = be_addr_ff;
					nxt_cfg_idx = cfg_idx_ff;
					nxt_st = ptb_pkg::ST_IDLE;
				end
			end
			// start in cycle 3, claim follows
			ptb_pkg::ST_START:
				nxt_st = ptb_pkg::ST_CLAIM;
			ptb_pkg::ST_CLAIM:
			begin
				nxt_cnt = 2'h0;
				nxt_valid = 1'b0;
				nxt_st = ptb_pkg::ST_DATA;
			end
			ptb_pkg::ST_DATA:
			begin
				if (cnt_ff != `PTB_CNT_MAX)
					nxt_cnt = cnt_ff + 2'h1;
				if (cfg_ff)
				begin
					if (rd_ff && cnt_ff == (`PTB_CFG_RD_WAIT - 2'h1))
					begin
						nxt_ad_out = {32'h0000_0000, cfg_word(cfg_idx_ff, cfg_rdata, bar0_ff, bar1_ff)};
						nxt_valid = 1'b1;
					end
					// each config data phase steps the index
					if (xfer)
					begin
						nxt_cnt = 2'h0;
						nxt_valid = 1'b0;
						nxt_cfg_idx = cfg_idx_ff + 6'h01;
						if (wr_ff && cfg_idx_ff == `PTB_BAR0_IDX && lanes[3])
							nxt_bar0 = pci_in.ad[31:`PTB_BAR0_W];
						if (wr_ff && cfg_idx_ff == `PTB_BAR1_IDX && lanes[3])
							nxt_bar1 = pci_in.ad[31:`PTB_BAR1_W];
					end
				end
				else if (rd_ff)
				begin
					// one word per clock while both sides are ready
					if (rd_strobe)
					begin
						nxt_ad_out = wide_ff ? be_in.rdata : {32'h0000_0000, be_in.rdata[31:0]};
						nxt_valid = 1'b1;
					end
					else if (xfer)
						nxt_valid = 1'b0;
				end
				else if (xfer)
				begin
					// written words reach the back-end next cycle
					nxt_wdata = wide_ff ? pci_in.ad : {32'h0000_0000, pci_in.ad[31:0]};
					nxt_qual = lanes;
					// upper lanes behave like the lower
					nxt_qual_hi = wide_ff ? ~pci_in.command_byte_enable_bus_n[7:4] : 4'h0;
				end
				// last data phase ends the claim
				if (xfer && pci_in.frame_n)
					nxt_st = ptb_pkg::ST_TURN;
			end
			ptb_pkg::ST_TURN:
				nxt_st = ptb_pkg::ST_DONE;
			default:
				nxt_st = ptb_pkg::ST_IDLE;
		endcase
		if (rd_strobe || (qual_ff != 4'h0))
			nxt_be_addr = be_addr_ff + (wide_ff ? `PTB_STEP64 : `PTB_STEP32);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= ptb_pkg::ST_IDLE;
			addr_ff <= 32'h0000_0000;
			cmd_ff <= 4'h0;
			cfg_sel_ff <= 1'b0;
			req64_ff <= 1'b0;
			frame_prev_ff <= 1'b1;
			prim_ff <= 1'b0;
			sec_ff <= 1'b0;
			cfg_ff <= 1'b0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			wide_ff <= 1'b0;
			cnt_ff <= 2'h0;
			valid_ff <= 1'b0;
			ad_out_ff <= 64'h0;
			be_addr_ff <= 22'h0;
			cfg_idx_ff <= 6'h00;
			wdata_ff <= 64'h0;
			qual_ff <= 4'h0;
			qual_hi_ff <= 4'h0;
			bar0_ff <= 8'h00;
			bar1_ff <= 20'h0_0000;
			par_ff <= 1'b0;
			par64_ff <= 1'b0;
			par_oe_ff <= 1'b0;
			par64_oe_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			addr_ff <= nxt_addr;
			cmd_ff <= nxt_cmd;
			cfg_sel_ff <= nxt_cfg_sel;
			req64_ff <= nxt_req64;
			frame_prev_ff <= nxt_frame_prev;
			prim_ff <= nxt_prim;
			sec_ff <= nxt_sec;
			cfg_ff <= nxt_cfg;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			wide_ff <= nxt_wide;
			cnt_ff <= nxt_cnt;
			valid_ff <= nxt_valid;
			ad_out_ff <= nxt_ad_out;
			be_addr_ff <= nxt_be_addr;
			cfg_idx_ff <= nxt_cfg_idx;
			wdata_ff <= nxt_wdata;
			qual_ff <= nxt_qual;
			qual_hi_ff <= nxt_qual_hi;
			bar0_ff <= nxt_bar0;
			bar1_ff <= nxt_bar1;
			par_ff <= nxt_par;
			par64_ff <= nxt_par64;
			par_oe_ff <= nxt_par_oe;
			par64_oe_ff <= nxt_par64_oe;
		end
	end

	// Bus pins; controls stay driven high for one turn-around cycle
	always_comb
	begin
		pci_out.ad_o = ad_out_ff;
		// upper half driven only in wide reads
		pci_out.ad_lo_oe = ad_lo_oe;
		pci_out.ad_hi_oe = ad_hi_oe;
		pci_out.devsel_n = !((st_ff == ptb_pkg::ST_CLAIM) || (st_ff == ptb_pkg::ST_DATA));
		pci_out.ack64_n = pci_out.devsel_n || !wide_ff;
		pci_out.trdy_n = !trdy;
		pci_out.stop_n = 1'b1;
		pci_out.ctl_oe = (st_ff == ptb_pkg::ST_CLAIM) || (st_ff == ptb_pkg::ST_DATA)
			|| (st_ff == ptb_pkg::ST_TURN);
		pci_out.par = par_ff;
		pci_out.par_oe = par_oe_ff;
		pci_out.par64 = par64_ff;
		pci_out.par64_oe = par64_oe_ff;
	end

	always_comb
	begin
		// start marks the cycle qualifiers become valid
		be_out.access_start_pulse = (st_ff == ptb_pkg::ST_START);
		be_out.wide_access_start_pulse = (st_ff == ptb_pkg::ST_START) && wide_ff;
		be_out.access_finished = (st_ff == ptb_pkg::ST_DONE);
		be_out.primary_space_hit = prim_ff;
		be_out.secondary_space_hit = sec_ff;
		be_out.config_space_access = cfg_ff;
		be_out.read_direction = rd_ff;
		be_out.write_direction = wr_ff;
		be_out.read_data_strobe = rd_strobe;
		be_out.read_data_strobe_upper = rd_strobe && wide_ff;
		be_out.write_lane_qualifier = qual_ff;
		be_out.write_lane_qualifier_upper = qual_hi_ff;
		be_out.addr = be_addr_ff;
		be_out.wdata = wdata_ff;
		// zero latency: data valid with its address
		be_out.backend_latency_count = `PTB_LATENCY;
	end

endmodule
`default_nettype wire

/* File: sim/ptb_target_props.sv */
// Assertion checker for the target burst back-end port
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"

module ptb_target_props (
	input wire logic                  mclk,    // Bus clock
	input wire logic                  rst_n,   // Async reset, active low
	input wire ptb_pkg::ptb_pci_in_s  pci_in,  // Bus pins sampled
	input wire ptb_pkg::ptb_pci_out_s pci_out, // Bus pins driven
	input wire ptb_pkg::ptb_be_in_s   be_in,   // Back-end inputs
	input wire ptb_pkg::ptb_be_out_s  be_out   // Back-end outputs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic [4:0] flags;
	logic       moved;
	logic       wide;
	assign flags = {be_out.primary_space_hit, be_out.secondary_space_hit,
		be_out.config_space_access, be_out.read_direction, be_out.write_direction};
	assign moved = be_out.read_data_strobe || |be_out.write_lane_qualifier;
	assign wide  = be_out.read_data_strobe_upper || |be_out.write_lane_qualifier_upper;

	// Single-phase config access: frame seen falling with select, then released
	sequence s_cfg(logic [3:0] cmd);
		$fell(pci_in.frame_n) && pci_in.idsel
			&& pci_in.command_byte_enable_bus_n[3:0] == cmd ##1 pci_in.frame_n;
	endsequence

	a_start_timing: assert property (
		be_out.access_start_pulse |-> !$past(pci_in.frame_n, 2) && $past(pci_in.frame_n, 3))
		else $error("start pulse not two cycles after address phase");
	a_start_claim: assert property (
		be_out.access_start_pulse |=> !be_out.access_start_pulse && !pci_out.devsel_n)
		else $error("start pulse too long or claim late");
	a_wide_claim: assert property (
		be_out.wide_access_start_pulse |-> be_out.access_start_pulse
			&& !$past(pci_in.req64_n, 2) ##1 !pci_out.ack64_n && !pci_out.devsel_n)
		else $error("wide start without wide request or acknowledge");
	a_ack_mirror: assert property (
		!pci_out.ack64_n |-> !pci_out.devsel_n)
		else $error("wide acknowledge without claim");
	a_flags_held: assert property (
		$changed(flags) |-> be_out.access_start_pulse)
		else $error("space or direction flags moved between starts");
	a_cfg_write: assert property (
		s_cfg(`PTB_CMD_CFG_WR) |-> ##2 !pci_out.devsel_n && pci_out.trdy_n
			##1 !pci_out.trdy_n ##1 pci_out.trdy_n)
		else $error("config write handshake off");
	a_cfg_read: assert property (
		s_cfg(`PTB_CMD_CFG_RD) |-> pci_out.trdy_n[*5]
			##1 (!pci_out.trdy_n && pci_out.ad_lo_oe) ##1 pci_out.trdy_n)
		else $error("config read handshake off");
	a_lane_xfer: assert property (
		|be_out.write_lane_qualifier |-> !$past(pci_out.trdy_n) && !$past(pci_in.irdy_n)
			&& be_out.wdata[31:0] == $past(pci_in.ad[31:0])
			&& be_out.write_lane_qualifier == ~$past(pci_in.command_byte_enable_bus_n[3:0]))
		else $error("write qualifier without transfer or data");
	a_upper_pair: assert property (
		|be_out.write_lane_qualifier_upper |-> |be_out.write_lane_qualifier
			&& be_out.wdata[63:32] == $past(pci_in.ad[63:32]))
		else $error("upper qualifier unpaired");
	a_addr_step: assert property (
		$past(moved) |-> be_out.addr == $past(be_out.addr)
			+ ($past(wide) ? `PTB_STEP64 : `PTB_STEP32))
		else $error("back-end address step wrong");
	a_read_pass: assert property (
		$past(be_out.read_data_strobe) && !pci_out.trdy_n
			|-> pci_out.ad_o[31:0] == $past(be_in.rdata[31:0]))
		else $error("read word not passed on the next cycle");
	a_done_turn: assert property (
		be_out.access_finished |-> $past(pci_out.ctl_oe) && !pci_out.ctl_oe
			&& pci_out.devsel_n)
		else $error("finish pulse not right after turn-around");
	a_par_track: assert property (
		pci_out.par_oe |-> $past(pci_out.ad_lo_oe)
			&& pci_out.par == ^{$past(pci_out.ad_o[31:0]),
			$past(pci_in.command_byte_enable_bus_n[3:0])})
		else $error("parity does not follow driven data");
endmodule

bind ptb_target ptb_target_props u_props (
	.mclk    (mclk),
	.rst_n   (rst_n),
	.pci_in  (pci_in),
	.pci_out (pci_out),
	.be_in   (be_in),
	.be_out  (be_out)
);
`default_nettype wire

/* File: sim/ptb_backend_model.sv */
// Behavioural back-end memory facing the port
`timescale 1ns/1ps
`default_nettype none

module ptb_backend_model (
	input  wire logic                 mclk,   // Bus clock
	input  wire logic                 slow,   // Hold ready off after each start
	input  wire ptb_pkg::ptb_be_out_s be_out, // Strobes from the port
	output ptb_pkg::ptb_be_in_s       be_in   // Ready and read data
);
	logic [31:0] mem [64];
	logic [2:0]  wait_cnt = 3'h0;
	logic [5:0]  a;
	assign a = be_out.addr[5:0];

	assign be_in.backend_write_ready = !slow || wait_cnt == 3'h0;
	assign be_in.backend_read_ready  = !slow || wait_cnt == 3'h0;

	// zero latency: the word at the address is always fetched ahead
	// Outside reads the bus shows the inverse of the write data the port last held, which can be stale
	assign be_in.rdata = be_out.read_direction ? {mem[a + 6'h1], mem[a]} : ~be_out.wdata;

	always @(posedge mclk)
	begin
		if (be_out.access_start_pulse)
			wait_cnt <= 3'h4;
		else if (wait_cnt != 3'h0)
			wait_cnt <= wait_cnt - 3'h1;
		for (int i = 0; i < 4; i++)
		begin
			if (be_out.write_lane_qualifier[i])
				mem[a][8*i +: 8] <= be_out.wdata[8*i +: 8];
			if (be_out.write_lane_qualifier_upper[i])
				mem[a + 6'h1][8*i +: 8] <= be_out.wdata[32 + 8*i +: 8];
		end
	end
endmodule
`default_nettype wire

/* File: sim/tb_ptb_target.sv */
// Self-checking testbench for the target burst back-end port
`timescale 1ns/1ps
`default_nettype none
`include "ptb_defines.svh"

module tb_ptb_target;
	logic                  mclk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  slow = 1'b0;
	ptb_pkg::ptb_pci_in_s  pin;
	ptb_pkg::ptb_pci_out_s pout;
	ptb_pkg::ptb_be_in_s   bin;
	ptb_pkg::ptb_be_out_s  bout;
	logic [63:0]           wbuf [8];
	logic [63:0]           rbuf [8];
	int                    done_n;
	int                    err_count = 0;
	int                    checks = 0;

	always #5 mclk = ~mclk;

	ptb_target dut (.mclk(mclk), .rst_n(rst_n), .pci_in(pin), .pci_out(pout),
		.be_in(bin), .be_out(bout));
	ptb_backend_model u_model (.mclk(mclk), .slow(slow), .be_out(bout), .be_in(bin));

	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		checks++;
		if (seen !== want)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	// Bus master: holds each data phase until the target is ready or 20+n clocks pass in all for the transfer, then releases
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
		input logic w64, input int n, input logic wr);
		int t;
		t = 0;
		done_n = 0;
		@(posedge mclk);
		pin.frame_n <= 1'b0;
		pin.req64_n <= !w64;
		pin.idsel <= sel;
		pin.ad <= {32'h0, a};
		pin.command_byte_enable_bus_n <= {4'h0, cmd};
		@(posedge mclk);
		pin.frame_n <= n == 1;
		pin.req64_n <= n == 1 || !w64;
		pin.idsel <= 1'b0;
		pin.irdy_n <= 1'b0;
		pin.command_byte_enable_bus_n <= 8'h00;
		pin.ad <= wr ? wbuf[0] : ~{32'h0, a};
		while (done_n < n && t < 20 + n)
		begin
			@(posedge mclk);
			t++;
			if (pout.trdy_n === 1'b0)
			begin
				rbuf[done_n] = pout.ad_o;
				done_n++;
				pin.frame_n <= done_n >= n - 1;
				pin.req64_n <= done_n >= n - 1 || !w64;
				pin.irdy_n <= done_n >= n;
				pin.ad <= wr ? wbuf[done_n] : ~{32'h0, a};
			end
		end
		if (done_n < n)
		begin
			pin.frame_n <= 1'b1;
			pin.req64_n <= 1'b1;
			pin.irdy_n <= 1'b1;
		end
		repeat (4) @(posedge mclk);
	endtask

	task automatic t_config;
		wbuf[0] = 64'ha5c3_1e07;
		xfer(`PTB_CMD_CFG_WR, 32'h40, 1'b1, 1'b0, 1, 1'b1);
		wbuf[0] = 64'h0123_4567;
		wbuf[1] = 64'h89ab_cdef;
		xfer(`PTB_CMD_CFG_WR, 32'h44, 1'b1, 1'b0, 2, 1'b1);
		xfer(`PTB_CMD_CFG_RD, 32'h40, 1'b1, 1'b0, 1, 1'b0);
		chk({32'h0, rbuf[0][31:0]}, 64'ha5c3_1e07);
		xfer(`PTB_CMD_CFG_RD, 32'h44, 1'b1, 1'b0, 2, 1'b0);
		chk({rbuf[1][31:0], rbuf[0][31:0]}, 64'h89ab_cdef_0123_4567);
		// Move both spaces off zero so that stray addresses miss
		wbuf[0] = 64'h1000_0000;
		xfer(`PTB_CMD_CFG_WR, 32'h10, 1'b1, 1'b0, 1, 1'b1);
		wbuf[0] = 64'h2000_0000;
		xfer(`PTB_CMD_CFG_WR, 32'h14, 1'b1, 1'b0, 1, 1'b1);
		$display("config test done");
	endtask

	task automatic burst(input logic [31:0] a, input logic w64, input int n,
		input logic [1:0] hit);
		logic [63:0] msk;
		msk = w64 ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
		for (int i = 0; i < n; i++)
			wbuf[i] = {~a, a} + 64'(i) * 64'h0000_0100_0000_0001;
		xfer(`PTB_CMD_MEM_WR, a, 1'b0, w64, n, 1'b1);
		chk(64'(done_n), 64'(n));
		chk(64'({bout.primary_space_hit, bout.secondary_space_hit, bout.config_space_access,
			bout.read_direction, bout.write_direction}), 64'({hit, 3'b001}));
		xfer(`PTB_CMD_MEM_RD, a, 1'b0, w64, n, 1'b0);
		chk(64'({bout.read_direction, bout.write_direction}), 64'h2);
		for (int i = 0; i < n; i++)
			chk(rbuf[i] & msk, wbuf[i] & msk);
	endtask

	task automatic t_mem;
		burst(32'h1000_0040, 1'b0, 4, 2'b10);
		burst(32'h1000_0080, 1'b1, 3, 2'b10);
		burst(32'h2000_0100, 1'b0, 2, 2'b01);
		$display("memory burst test done");
	endtask

	task automatic t_slow;
		@(posedge mclk);
		slow <= 1'b1;
		burst(32'h1000_00c0, 1'b0, 3, 2'b10);
		slow <= 1'b0;
		$display("slow back-end test done");
	endtask

	task automatic t_miss;
		logic [3:0]  cmd [4] = '{`PTB_CMD_MEM_RD, 4'h2, 4'h3, `PTB_CMD_CFG_RD};
		logic [31:0] adr [4] = '{32'h3000_0000, 32'h1000_0040, 32'h1000_0040, 32'h40};
		for (int i = 0; i < 4; i++)
		begin
			xfer(cmd[i], adr[i], 1'b0, 1'b0, 1, 1'b0);
			chk(64'(done_n), 64'h0);
		end
		$display("refused cycle test done");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		pin = '0;
		pin.frame_n = 1'b1;
		pin.irdy_n = 1'b1;
		pin.req64_n = 1'b1;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		t_config;
		t_mem;
		t_slow;
		t_miss;
		stop_test;
	end

	// The whole run needs well under a thousand cycles; five thousand means a hang
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_count++;
		stop_test;
	end
endmodule
`default_nettype wire
